/* File: logic/acr_lowpass.sv */
// First-order low-pass stage, one step per strobe.
// Assumes step and load are single-cycle strobes on core_clk.
`timescale 1ns/10ps
`default_nettype none
module acr_lowpass
    import acr_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic step,
    input wire logic load,
    input wire logic [15:0] coef,
    input wire logic signed [15:0] sampleIn,
    output logic signed [15:0] filtOut
);
    typedef struct packed {
        logic signed [15:0] acc;
    } acr_lp_s;

    acr_lp_s st;
    acr_lp_s next_st;
    logic signed [16:0] delta;
    logic signed [33:0] prod;

    always_comb begin
        delta = 17'(sampleIn) - 17'(st.acc);
        prod = delta * $signed({1'b0, coef});
        next_st = st;
        // Loading avoids a long settle from zero after a new binding
        if (load) begin
            next_st.acc = sampleIn;
        end else if (step) begin
            next_st.acc = 16'(st.acc + prod[31:16]);
        end
        if (sys_rst) begin
            next_st = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        st <= next_st;
    end

    assign filtOut = st.acc;
endmodule // acr_lowpass
`default_nettype wire

/* File: logic/acr_pkg.sv */
// Shared constants, field layouts and carriers of the analog readout block.
// Assumes a 100 MHz core clock and a classic Wishbone master.
package acr_pkg;
    // Timing
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_US = 120;
    localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    localparam int FILT_MS = 5;
    // First-order step size for the fixed 5 ms smoothing at one step a tick
    localparam logic [15:0] BASE_COEF =
        16'(65536 * TICK_US / (FILT_MS * 1000));

    // Converter inputs and scaling
    localparam int NCONV = 21;
    localparam int CONV_W = 12;
    localparam int STD_W = 10;
    localparam int STD_SHIFT = 5;
    localparam int EXT_SHIFT = 3;
    localparam logic [15:0] STD_MAX = 16'((2 ** STD_W - 1) << STD_SHIFT);
    localparam logic [15:0] EXT_MAX = 16'((2 ** CONV_W - 1) << EXT_SHIFT);

    // Channel codes and their converter slots
    localparam logic [4:0] CH_OFF = 5'h00;
    localparam logic [4:0] CH_AIN_HI = 5'h04;
    localparam logic [4:0] CH_DIFF12 = 5'h05;
    localparam logic [4:0] CH_DIFF34 = 5'h06;
    localparam logic [4:0] CH_INT_LO = 5'h07;
    localparam logic [4:0] CH_INT_HI = 5'h0c;
    localparam logic [4:0] CH_VEL = 5'h0d;
    localparam logic [4:0] CH_TRQ = 5'h0e;
    localparam logic [4:0] CH_PERR = 5'h0f;
    localparam logic [4:0] CH_IO_LO = 5'h10;
    localparam logic [4:0] CH_IO_HI = 5'h19;
    localparam logic [4:0] CH_MOTOR = 5'h1c;
    localparam logic [4:0] AIN_OFS = 5'h01;
    localparam logic [4:0] INT_OFS = 5'h03;
    localparam logic [4:0] IO_OFS = 5'h06;
    localparam logic [4:0] MOTOR_SLOT = 5'h14;

    // Register map (byte addresses)
    localparam logic [7:0] ADR_STD = 8'h00;
    localparam logic [7:0] ADR_ONE = 8'h04;
    localparam logic [7:0] ADR_EXT_CHAN = 8'h08;
    localparam logic [7:0] ADR_EXT_FILT = 8'h0c;
    localparam logic [7:0] ADR_EXT_DEST = 8'h10;
    localparam logic [7:0] ADR_STATUS = 8'h14;
    localparam logic [7:0] ADR_UDR = 8'h20;
    localparam int NUDR = 8;
    localparam int UDR_IW = 3;
    localparam logic [7:0] ADR_UDR_END = 8'(ADR_UDR + 4 * NUDR);

    // Field layout
    localparam int CHAN_LSB = 0;
    localparam int STD_CHAN_W = 4;
    localparam int EXT_CHAN_W = 5;
    localparam int COEF_LSB = 4;
    localparam int COEF_W = 12;
    localparam int DEST_LSB = 16;
    localparam int ST_STD = 0;
    localparam int ST_EXT = 1;
    localparam int ST_ONE = 2;

    typedef logic [NCONV-1:0][CONV_W-1:0] acr_conv_t;

    typedef struct packed {
        logic signed [15:0] velocity;
        logic signed [15:0] torque;
        logic signed [15:0] posErr;
    } acr_int_s;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } acr_wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } acr_wb_rsp_s;

    function automatic logic [31:0] wb_merge(input logic [31:0] old,
        input logic [31:0] din, input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = din[8*i +: 8];
            end
        end
        return res;
    endfunction
endpackage

/* File: logic/acr_readout.sv */
// Analog channel readout engine with a classic Wishbone register slave.
// Assumes conversions arrive asynchronously; internal quantities on core_clk.
// Behaviour
// - Standard continuous read samples once per 120 us tick into register.
// - Only one standard binding; a new command replaces the old one.
// - Standard path: 10-bit value, 5 ms filter, times 32, max 32736.
// - Extended path: 12-bit value, 5 ms filter, times 8, max 32760.
// - Standard word: coefficient in upper 12 bits, channel in lower 4.
// - Codes 1-4 single inputs; 5 pairs inputs one-two, 6 three-four.
// - Channel code zero disables the readout, no more register updates.
// - Codes 7-12 internal quantities; 13 velocity, 14 torque, 15 error.
// - Extended codes 16-25 I/O sources, 26-27 reserved, 28 motor input.
// - Single-shot converts once, writes one result, then stops.
// - Extended command: channel, coefficient, register as separate words.
// - Nonzero extended coefficient adds a first-order low-pass stage.
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module acr_readout
    import acr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire acr_wb_req_s wbReq,
    output var acr_wb_rsp_s wbRsp,
    input wire acr_conv_t convIn,
    input wire acr_int_s internalIn
);
    localparam int TW = $clog2(TICK_CYCLES);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

    typedef struct packed {
        acr_conv_t sync1;
        acr_conv_t sync2;
        logic [TW-1:0] tickCnt;
        logic [31:0] stdCmd;
        logic [31:0] oneCmd;
        logic [31:0] extChan;
        logic [31:0] extFilt;
        logic [31:0] extDest;
        logic stdOn;
        logic extOn;
        logic onePend;
        logic stdLoad;
        logic extLoad;
        logic stdWr;
        logic extWr;
        logic [NUDR-1:0][15:0] udr;
        acr_wb_rsp_s rsp;
    } acr_top_s;

    acr_top_s st;
    acr_top_s next_st;

    logic tick;
    logic busReq;
    logic [31:0] rd;
    logic [31:0] wval;
    logic [4:0] stdChan;
    logic [4:0] extChan;
    logic [4:0] oneChan;
    logic [UDR_IW-1:0] stdDest;
    logic [UDR_IW-1:0] extDest;
    logic [UDR_IW-1:0] oneDest;
    logic [15:0] stdCoef;
    logic [15:0] extCoef;
    logic signed [15:0] stdSample;
    logic signed [15:0] extSample;
    logic signed [15:0] oneSample;
    logic stdValid;
    logic extValid;
    logic oneValid;
    logic stdStep;
    logic extStep;
    logic signed [15:0] stdBase;
    logic signed [15:0] stdLp;
    logic signed [15:0] extBase;
    logic signed [15:0] extLp;
    logic signed [15:0] stdOut;
    logic signed [15:0] extOut;
    logic stdLoadNow;
    logic extLoadNow;
    logic signed [15:0] stdLpIn;
    logic signed [15:0] extLpIn;

    // Field decode of the command words
    assign stdChan = 5'(st.stdCmd[CHAN_LSB +: STD_CHAN_W]);
    assign stdCoef = 16'(st.stdCmd[COEF_LSB +: COEF_W])
        << (16 - COEF_W);
    assign stdDest = st.stdCmd[DEST_LSB +: UDR_IW];
    assign oneChan = 5'(st.oneCmd[CHAN_LSB +: STD_CHAN_W]);
    assign oneDest = st.oneCmd[DEST_LSB +: UDR_IW];
    assign extChan = st.extChan[CHAN_LSB +: EXT_CHAN_W];
    assign extCoef = st.extFilt[15:0];
    assign extDest = st.extDest[UDR_IW-1:0];

    assign tick = (st.tickCnt == TICK_LAST);
    assign stdStep = tick && st.stdOn && stdValid;
    assign extStep = tick && st.extOn && extValid;
    // Zero coefficient bypasses the extra stage rather than freezing it
    assign stdOut = (stdCoef != '0) ? stdLp : stdBase;
    assign extOut = (extCoef != '0) ? extLp : extBase;
    // The extra stage preloads from the fresh sample, not the stale base
    // value, so a new binding reports its first reading without a settle
    assign stdLoadNow = stdStep && st.stdLoad;
    assign extLoadNow = extStep && st.extLoad;
    assign stdLpIn = stdLoadNow ? stdSample : stdBase;
    assign extLpIn = extLoadNow ? extSample : extBase;

    acr_source_mux u_std_mux (
        .core_clk(core_clk), .sys_rst(sys_rst), .extMode(1'b0),
        .chan(stdChan), .conv(st.sync2), .internal(internalIn),
        .sample(stdSample), .valid(stdValid)
    );
    acr_source_mux u_ext_mux (
        .core_clk(core_clk), .sys_rst(sys_rst), .extMode(1'b1),
        .chan(extChan), .conv(st.sync2), .internal(internalIn),
        .sample(extSample), .valid(extValid)
    );
    acr_source_mux u_one_mux (
        .core_clk(core_clk), .sys_rst(sys_rst), .extMode(1'b0),
        .chan(oneChan), .conv(st.sync2), .internal(internalIn),
        .sample(oneSample), .valid(oneValid)
    );

    acr_lowpass u_std_base (
        .core_clk(core_clk), .sys_rst(sys_rst), .step(stdStep),
        .load(stdLoadNow), .coef(BASE_COEF),
        .sampleIn(stdSample), .filtOut(stdBase)
    );
    acr_lowpass u_std_lp (
        .core_clk(core_clk), .sys_rst(sys_rst), .step(stdStep),
        .load(stdLoadNow), .coef(stdCoef),
        .sampleIn(stdLpIn), .filtOut(stdLp)
    );
    acr_lowpass u_ext_base (
        .core_clk(core_clk), .sys_rst(sys_rst), .step(extStep),
        .load(extLoadNow), .coef(BASE_COEF),
        .sampleIn(extSample), .filtOut(extBase)
    );
    acr_lowpass u_ext_lp (
        .core_clk(core_clk), .sys_rst(sys_rst), .step(extStep),
        .load(extLoadNow), .coef(extCoef),
        .sampleIn(extLpIn), .filtOut(extLp)
    );

    assign busReq = wbReq.cyc && wbReq.stb && !st.rsp.ack;

    always_comb begin
        rd = '0;
        unique case (wbReq.adr)
            ADR_STD: rd = st.stdCmd;
            ADR_ONE: rd = st.oneCmd;
            ADR_EXT_CHAN: rd = st.extChan;
            ADR_EXT_FILT: rd = st.extFilt;
            ADR_EXT_DEST: rd = st.extDest;
            ADR_STATUS: begin
                rd[ST_STD] = st.stdOn;
                rd[ST_EXT] = st.extOn;
                rd[ST_ONE] = st.onePend;
            end
            default: begin
                if (wbReq.adr >= ADR_UDR && wbReq.adr < ADR_UDR_END
                    && wbReq.adr[1:0] == 2'h0) begin
                    rd = 32'(st.udr[wbReq.adr[2 +: UDR_IW]]);
                end
            end
        endcase
    end

    always_comb begin
        next_st = st;
        wval = '0;
        next_st.sync1 = convIn;
        next_st.sync2 = st.sync1;
        next_st.tickCnt = tick ? '0 : TW'(st.tickCnt + 1'b1);
        next_st.stdWr = stdStep;
        next_st.extWr = extStep;
        if (stdStep) begin
            next_st.stdLoad = 1'b0;
        end
        if (extStep) begin
            next_st.extLoad = 1'b0;
        end
        // Writes land one cycle after the tick, once the filters stepped
        if (st.stdWr) begin
            next_st.udr[stdDest] = stdOut;
        end
        if (st.extWr) begin
            next_st.udr[extDest] = extOut;
        end
        if (tick && st.onePend) begin
            next_st.onePend = 1'b0;
            if (oneValid) begin
                next_st.udr[oneDest] = oneSample;
            end
        end
        next_st.rsp.ack = busReq;
        if (busReq) begin
            next_st.rsp.dat = rd;
        end
        // Bus commands come last so a new command beats the tick update
        if (busReq && wbReq.we) begin
            unique case (wbReq.adr)
                ADR_STD: begin
                    wval = wb_merge(st.stdCmd, wbReq.dat, wbReq.sel);
                    next_st.stdCmd = wval;
                    next_st.stdOn = wval[CHAN_LSB +: STD_CHAN_W]
                        != '0;
                    next_st.stdLoad = 1'b1;
                end
                ADR_ONE: begin
                    wval = wb_merge(st.oneCmd, wbReq.dat, wbReq.sel);
                    next_st.oneCmd = wval;
                    next_st.onePend = wval[CHAN_LSB +: STD_CHAN_W]
                        != '0;
                end
                // A half-written command must not steer the running binding
                ADR_EXT_CHAN: begin
                    next_st.extChan = wb_merge(st.extChan, wbReq.dat,
                        wbReq.sel);
                    next_st.extOn = 1'b0;
                end
                ADR_EXT_FILT: begin
                    next_st.extFilt = wb_merge(st.extFilt, wbReq.dat,
                        wbReq.sel);
                    next_st.extOn = 1'b0;
                end
                ADR_EXT_DEST: begin
                    next_st.extDest = wb_merge(st.extDest, wbReq.dat,
                        wbReq.sel);
                    next_st.extOn = extChan != CH_OFF;
                    next_st.extLoad = 1'b1;
                end
                default: begin
                end
            endcase
        end
        if (sys_rst) begin
            next_st = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        st <= next_st;
    end

    assign wbRsp = st.rsp;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    logic stdCmdWr;
    assign stdCmdWr = busReq && wbReq.we && wbReq.adr == ADR_STD
        && wbReq.sel == 4'hf;
    logic oneArm;
    logic extCfgWr;
    logic extCommit;
    assign oneArm = busReq && wbReq.we && wbReq.adr == ADR_ONE;
    assign extCfgWr = busReq && wbReq.we
        && (wbReq.adr == ADR_EXT_CHAN || wbReq.adr == ADR_EXT_FILT);
    assign extCommit = busReq && wbReq.we && wbReq.adr == ADR_EXT_DEST;

    a_std_tick_write: assert property (st.stdWr
        && !(st.extWr && extDest == stdDest)
        |=> st.udr[$past(stdDest)] == $past(stdOut))
        else $error("standard result not written after tick");
    a_tick_spacing: assert property (tick |=> !tick [*8])
        else $error("ticks too close");
    a_std_rebind: assert property (stdCmdWr
        |=> st.stdLoad && st.stdOn == ($past(wbReq.dat[3:0]) != 4'h0))
        else $error("standard binding not replaced");
    a_std_fields: assert property (stdCmdWr |=>
        stdChan == 5'($past(wbReq.dat[3:0]))
        && stdCoef[15:4] == $past(wbReq.dat[15:4]))
        else $error("standard word fields decoded wrong");
    a_idle_no_update: assert property (!st.stdOn && !st.extOn
        && !st.onePend && !st.stdWr && !st.extWr |=> $stable(st.udr))
        else $error("register changed while disabled");
    a_single_once: assert property (tick && st.onePend && oneValid
        && !oneArm
        |=> !st.onePend && st.udr[$past(oneDest)] == $past(oneSample))
        else $error("single read not completed");
    a_ext_tick_write: assert property (st.extWr
        |=> st.udr[$past(extDest)] == $past(extOut))
        else $error("extended result not written");
    a_ext_lowpass: assert property (st.extWr && extCoef != 16'h0000
        |=> st.udr[$past(extDest)] == $past(extLp))
        else $error("extended low-pass stage skipped");
    a_bus_ack: assert property (busReq |=> st.rsp.ack ##1 !st.rsp.ack)
        else $error("bus ack not one cycle");
    a_ext_partial_off: assert property (extCfgWr |=> !st.extOn)
        else $error("extended binding kept during a partial command");
    a_ext_commit: assert property (extCommit
        |=> st.extLoad && st.extOn == ($past(extChan) != CH_OFF))
        else $error("extended command not committed");
    a_std_preload: assert property (stdLoadNow |=> stdLp == stdBase)
        else $error("standard extra stage not preloaded");
    a_ext_preload: assert property (extLoadNow |=> extLp == extBase)
        else $error("extended extra stage not preloaded");

    c_std_update: cover property (st.stdWr);
    c_ext_update: cover property (st.extWr && extCoef != 16'h0000);
    c_single_done: cover property (st.onePend ##1 !st.onePend);
    c_rebind: cover property (st.stdOn && stdCmdWr);
endmodule // acr_readout
`default_nettype wire

/* File: logic/acr_source_mux.sv */
// Channel-code decode: picks a converter slot or internal quantity, scales.
// Assumes conversions are already synchronised to core_clk.
`timescale 1ns/10ps
`default_nettype none
module acr_source_mux
    import acr_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic extMode,
    input wire logic [4:0] chan,
    input wire acr_conv_t conv,
    input wire acr_int_s internal,
    output logic signed [15:0] sample,
    output logic valid
);
    function automatic logic [15:0] scale(input logic [CONV_W-1:0] raw,
        input logic ext);
        if (ext) begin
            return 16'(raw) << EXT_SHIFT;
        end
        return 16'(raw >> (CONV_W - STD_W)) << STD_SHIFT;
    endfunction

    // Negative differences clamp, since results are non-negative words
    function automatic logic [CONV_W-1:0] diff(input logic [CONV_W-1:0] a,
        input logic [CONV_W-1:0] b);
        return (a > b) ? CONV_W'(a - b) : '0;
    endfunction

    always_comb begin
        sample = '0;
        valid = 1'b0;
        if (chan != CH_OFF && chan <= CH_AIN_HI) begin
            sample = scale(conv[5'(chan - AIN_OFS)], extMode);
            valid = 1'b1;
        end else if (chan == CH_DIFF12) begin
            sample = scale(diff(conv[0], conv[1]), extMode);
            valid = 1'b1;
        end else if (chan == CH_DIFF34) begin
            sample = scale(diff(conv[2], conv[3]), extMode);
            valid = 1'b1;
        end else if (chan >= CH_INT_LO && chan <= CH_INT_HI) begin
            sample = scale(conv[5'(chan - INT_OFS)], extMode);
            valid = 1'b1;
        end else if (chan == CH_VEL) begin
            sample = internal.velocity;
            valid = 1'b1;
        end else if (chan == CH_TRQ) begin
            sample = internal.torque;
            valid = 1'b1;
        end else if (chan == CH_PERR) begin
            sample = internal.posErr;
            valid = 1'b1;
        end else if (extMode && chan >= CH_IO_LO && chan <= CH_IO_HI) begin
            sample = scale(conv[5'(chan - IO_OFS)], 1'b1);
            valid = 1'b1;
        end else if (extMode && chan == CH_MOTOR) begin
            sample = scale(conv[MOTOR_SLOT], 1'b1);
            valid = 1'b1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_std_scale_max: assert property (!extMode && chan != CH_OFF
        && chan <= CH_INT_HI |-> sample <= STD_MAX && sample[4:0] == 5'h00)
        else $error("standard sample out of scale");
    a_ext_scale_max: assert property (extMode && chan != CH_OFF
        && chan <= CH_INT_HI |-> sample <= EXT_MAX && sample[2:0] == 3'h0)
        else $error("extended sample out of scale");
    a_diff_pair: assert property (chan == CH_DIFF34 && !extMode
        |-> (conv[2] > conv[3])
        ? sample[14:5] == 10'((conv[2] - conv[3]) >> (CONV_W - STD_W))
        : sample == 16'h0000)
        else $error("differential pair three-four wrong");
    a_vel_source: assert property (chan == CH_VEL
        |-> valid && sample == internal.velocity)
        else $error("velocity code not routed");
    a_reserved_code: assert property (extMode && chan > CH_IO_HI
        && chan < CH_MOTOR |-> !valid)
        else $error("reserved code produced a sample");
    a_shift_form: assert property (!extMode && chan == AIN_OFS
        |-> sample == {1'b0, conv[0][CONV_W-1:CONV_W-STD_W], 5'h00})
        else $error("standard shift form wrong");
endmodule // acr_source_mux
`default_nettype wire

/* File: testbench/acr_conv_model.sv */
// Behavioural converter front end: scanned analog inputs, internal values.
// Assumes the bench sets the levels; a scan lands every SCAN_CYCLES cycles.
`timescale 1ns/10ps
`default_nettype none
module acr_conv_model
    import acr_pkg::*;
#(
    parameter int SCAN_CYCLES = 4
) (
    input wire logic core_clk,
    input wire acr_conv_t levelIn,
    input wire acr_int_s quantIn,
    output var acr_conv_t convOut,
    output var acr_int_s internalOut
);
    int scanCnt = 0;
    // Levels only show once a scan completes, so the block sees them late
    always @(posedge core_clk) begin
        scanCnt <= (scanCnt + 1) % SCAN_CYCLES;
        if (scanCnt == 0) begin
            convOut <= levelIn;
        end
        internalOut <= quantIn;
    end
endmodule // acr_conv_model
`default_nettype wire

/* File: testbench/tb_analog_channel_readout.sv */
// Self-checking bench of the readout engine over classic Wishbone.
// Assumes the converter model in acr_conv_model and a shortened tick.
`timescale 1ns/10ps
`default_nettype none
module tb_analog_channel_readout
    import acr_pkg::*;
;
    localparam int TICK = 32;
    logic core_clk, sys_rst;
    acr_wb_req_s wbReq;
    acr_wb_rsp_s wbRsp;
    acr_conv_t level, convIn;
    acr_int_s quant, internalIn;
    int failCount = 0;
    int checkCount = 0;
    int seed;
    logic [32:0] expQ[$];
    logic [32:0] item;
    logic [31:0] rd;
    logic [31:0] shadow[8];
    logic [2:0] d;

    acr_readout #(.TICK_CYCLES(TICK)) i_dut (.core_clk(core_clk),
        .sys_rst(sys_rst), .wbReq(wbReq), .wbRsp(wbRsp), .convIn(convIn),
        .internalIn(internalIn));
    acr_conv_model i_conv (.core_clk(core_clk), .levelIn(level),
        .quantIn(quant), .convOut(convIn), .internalOut(internalIn));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic results;
        if (failCount == 0 && checkCount > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            failCount++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    // Request is held until the edge that samples ack high
    task automatic wbAcc(input logic we, input logic [7:0] a,
        input logic [31:0] v);
        @(posedge core_clk);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: v};
        do @(posedge core_clk); while (wbRsp.ack !== 1'b1);
        rd = wbRsp.dat;
        wbReq <= '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        wbAcc(1'b1, a, v);
    endtask

    task automatic rdExp(input logic [7:0] a, input logic [31:0] e);
        expQ.push_back({1'b1, e});
        wbAcc(1'b0, a, 32'h0);
    endtask

    task automatic rdRaw(input logic [7:0] a);
        expQ.push_back(33'h0);
        wbAcc(1'b0, a, 32'h0);
    endtask

    task automatic ext(input logic [4:0] c, input logic [15:0] f,
        input logic [2:0] dd);
        wr(ADR_EXT_CHAN, {27'h0, c});
        wr(ADR_EXT_FILT, {16'h0, f});
        wr(ADR_EXT_DEST, {29'h0, dd});
    endtask

    task automatic waitTicks(input int n);
        repeat (n * TICK + 8) @(posedge core_clk);
    endtask

    function automatic logic [7:0] udr(input logic [2:0] dd);
        return ADR_UDR + {3'h0, dd, 2'h0};
    endfunction

    function automatic logic [31:0] sx(input logic [11:0] v);
        return {17'h0, v[11:2], 5'h0};
    endfunction

    function automatic logic [31:0] stdExp(input int c);
        if (c <= 4) return sx(level[c-1]);
        if (c == 5) return sx(level[0] - level[1]);
        if (c == 6) return 32'h0;
        if (c <= 12) return sx(level[c-3]);
        if (c == 13) return {16'h0, quant.velocity};
        if (c == 14) return {16'h0, quant.torque};
        return {16'h0, quant.posErr};
    endfunction

    // Oldest note is matched to each read answer
    always @(posedge core_clk) begin
        if (wbRsp.ack === 1'b1 && wbReq.we === 1'b0 && expQ.size() > 0) begin
            item = expQ.pop_front();
            if (item[32]) begin
                check(wbRsp.dat, item[31:0]);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        failCount++;
        results();
    end

    initial begin
        seed = 32'hd29b404f;
        wbReq = '0;
        sys_rst = 1'b1;
        for (int i = 0; i < NCONV; i++) begin
            level[i] = 12'($random(seed)) & 12'hffc;
        end
        // Pair one-two differs by 0xbff; pair three-four goes negative so it clamps
        level[0] = 12'hfff;
        level[1] = 12'h400;
        level[2] = 12'h100;
        level[3] = 12'h800;
        level[10] = 12'hfff;
        quant = {16'($random(seed)) & 16'h7fff,
            16'($random(seed)) & 16'h7fff, 16'($random(seed)) & 16'h7fff};
        for (int i = 0; i < 8; i++) shadow[i] = 32'h0;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        rdExp(ADR_STATUS, 32'h0);
        rdExp(8'hfc, 32'h0);
        wr(udr(3'h3), 32'hffff);
        rdExp(udr(3'h3), 32'h0);
        for (int c = 1; c < 16; c++) begin
            d = c[2:0];
            wr(ADR_STD, {13'h0, d, 12'habc, c[3:0]});
            waitTicks(3);
            shadow[d] = stdExp(c);
            rdExp(udr(d), shadow[d]);
        end
        @(posedge core_clk);
        level[6] <= 12'h2a8;
        waitTicks(3);
        rdExp(udr(3'h1), shadow[1]);
        wr(ADR_STD, {13'h0, 3'h7, 16'h0});
        @(posedge core_clk);
        quant.posErr <= 16'h0123;
        waitTicks(3);
        rdExp(udr(3'h7), shadow[7]);
        rdExp(ADR_STATUS, 32'h0);
        wr(ADR_ONE, {13'h0, 3'h5, 12'h0, 4'h2});
        waitTicks(3);
        shadow[5] = sx(level[1]);
        rdExp(udr(3'h5), shadow[5]);
        rdExp(ADR_STATUS, 32'h0);
        @(posedge core_clk);
        level[1] <= 12'h124;
        waitTicks(3);
        rdExp(udr(3'h5), shadow[5]);
        for (int c = 16; c < 32; c++) begin
            d = c[2:0];
            ext(c[4:0], 16'h0, d);
            waitTicks(3);
            if (c < 26 || c == 28) begin
                shadow[d] = {17'h0, level[c == 28 ? 20 : c - 6], 3'h0};
            end
            rdExp(udr(d), shadow[d]);
        end
        ext(5'h10, 16'h8000, 3'h0);
        waitTicks(3);
        rdExp(udr(3'h0), 32'd32760);
        @(posedge core_clk);
        level[10] <= 12'h100;
        waitTicks(3);
        rdRaw(udr(3'h0));
        check({31'h0, rd < 32'd32760 && rd > 32'h800}, 32'h1);
        rdExp(ADR_STATUS, 32'h2);
        repeat (4) @(posedge core_clk);
        results();
    end
endmodule // tb_analog_channel_readout
`default_nettype wire
